/* File: core/trd_i2c_target.sv */
// I2C target with pinned temperature read, acquisition scheduler and hot queue
`timescale 1ns/1ns
`include "trd_defines.svh"
// Summary of operation
// - HOT only after 1/2/4/6 consecutive hot reads
// - Cool acquisition resets the queue counter
// - Writing queue clear resets the counter
// - Acquire every 60 s, store result
// - Pinned mode: reads return temperature register
// - Pinned mode: read pointer does not advance
// - Writes unaffected by pinned mode
// - Rails re-enable without clearing fault flags
// - Works at bus rates up to 400 kbit/s
// - Answers target address 1001 000
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - After write address ack, next byte is subaddress
// - Acknowledge address, subaddress and data bytes
// - Normal mode steps register address per byte
// - Transfer ends at stop or host NACK of a read byte
// - SDA only pulled low, never driven high
// - Temperature is saturated 8-bit two's complement
// - Each result compared to HOT threshold
// - Pinned control at 0x11, resets zero
module trd_i2c_target #(
	parameter longint unsigned ACQ_PERIOD_CYC = 64'(`TRD_ACQ_PERIOD_S) * 64'(`TRD_CLK_HZ)
) (
	// System
	input  wire logic               clk,
	input  wire logic               resetn,
	// I2C pins
	input  wire logic               scl_i,
	input  wire logic               sda_i,
	output logic                    sda_o,
	output logic                    sda_oe,
	// Converter
	output logic                    acq_start,
	input  wire logic               conv_done,
	input  wire logic signed [9:0]  conv_celsius,
	// Status
	output trd_pkg::trd_byte_t      temperature_result,
	output logic                    pinned_read_enable,
	output logic                    hot_alert,
	output logic                    rail_rearm_ok
);
	import trd_pkg::*;

	localparam int TW = $clog2(ACQ_PERIOD_CYC);

	if (ACQ_PERIOD_CYC < 64'd2) begin : g_chk
		$error("acquisition period too short");
	end

	// ----------------------------------------
	// Pin synchronisers and bus conditions
	// ----------------------------------------
	// Index 0 is the first stage, 2 is the previous value of stage 1
	logic [2:0] scl_sh_q;
	logic [2:0] sda_sh_q;

	// 100 MHz sampling leaves many samples per 400 kbit/s bit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_sh_q <= 3'h7;
			sda_sh_q <= 3'h7;
		end else begin
			scl_sh_q <= {scl_sh_q[1:0], scl_i};
			sda_sh_q <= {sda_sh_q[1:0], sda_i};
		end
	end

	wire scl_hi    = scl_sh_q[1] & scl_sh_q[2];
	wire scl_rise  = scl_sh_q[1] & ~scl_sh_q[2];
	wire scl_fall  = ~scl_sh_q[1] & scl_sh_q[2];
	wire sda_bit   = sda_sh_q[1];
	wire start_det = scl_hi & ~sda_sh_q[1] & sda_sh_q[2];
	wire stop_det  = scl_hi & sda_sh_q[1] & ~sda_sh_q[2];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	trd_byte_t regs_q [0:17];

	function automatic trd_byte_t reset_val(input logic [4:0] i);
		case (8'(i))
			`TRD_REG_CFG:  reset_val = `TRD_CFG_RST;
			`TRD_REG_HOT:  reset_val = `TRD_HOT_RST;
			`TRD_REG_COOL: reset_val = `TRD_COOL_RST;
			`TRD_REG_PIN:  reset_val = `TRD_PIN_RST;
			default:       reset_val = `TRD_TEMP_RST;
		endcase
	endfunction

	function automatic trd_byte_t saturate(input logic signed [9:0] v);
		if (v < `TRD_TEMP_MIN)
			saturate = `TRD_TEMP_MIN_B;
		else if (v > `TRD_TEMP_MAX)
			saturate = `TRD_TEMP_MAX_B;
		else
			saturate = v[7:0];
	endfunction

	wire pin_on = regs_q[5'(`TRD_REG_PIN)][`TRD_PIN_BIT];

	function automatic trd_byte_t read_reg(input trd_byte_t a);
		if (pin_on)
			read_reg = regs_q[5'(`TRD_REG_TEMP)];
		else if (a <= `TRD_REG_LAST)
			read_reg = regs_q[a[4:0]];
		else
			read_reg = 8'h00;
	endfunction

	// ----------------------------------------
	// Bus engine
	// ----------------------------------------
	trd_state_t state_q;
	logic [3:0] cnt_q;
	trd_byte_t  sr_q;
	trd_byte_t  tx_q;
	trd_byte_t  ptr_q;
	logic       rw_q;
	logic       rack_q;
	logic       oe_q;

	wire        rx_state  = state_q == ST_ADDR || state_q == ST_SUB || state_q == ST_WR;
	wire        byte_end  = scl_fall && cnt_q == 4'h8;
	wire        addr_hit  = sr_q[7:1] == `TRD_I2C_ADDR;
	wire        wr_fire   = state_q == ST_WR && byte_end;
	wire trd_byte_t np    = pin_on ? ptr_q : ptr_q + 8'h01;
	wire trd_byte_t first = read_reg(ptr_q);
	wire trd_byte_t nextb = read_reg(np);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
			sr_q    <= 8'h00;
			tx_q    <= 8'h00;
			ptr_q   <= 8'h00;
			rw_q    <= 1'b0;
			rack_q  <= 1'b1;
			oe_q    <= 1'b0;
		end else if (start_det) begin
			state_q <= ST_ADDR;
			cnt_q   <= 4'h0;
			oe_q    <= 1'b0;
		end else if (stop_det) begin
			state_q <= ST_IDLE;
			oe_q    <= 1'b0;
		end else begin
			if (scl_rise && rx_state) begin
				sr_q  <= {sr_q[6:0], sda_bit};
				cnt_q <= cnt_q + 4'h1;
			end
			if (scl_rise && state_q == ST_RACK)
				rack_q <= sda_bit;
			if (scl_fall) begin
				case (state_q)
					ST_ADDR: if (cnt_q == 4'h8) begin
						if (addr_hit) begin
							oe_q    <= 1'b1;
							rw_q    <= sr_q[0];
							state_q <= ST_AACK;
						end else begin
							state_q <= ST_IDLE;
						end
					end
					ST_AACK: begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							tx_q    <= {first[6:0], 1'b0};
							oe_q    <= ~first[7];
							cnt_q   <= 4'h1;
							state_q <= ST_RD;
						end else begin
							oe_q    <= 1'b0;
							state_q <= ST_SUB;
						end
					end
					ST_SUB: if (cnt_q == 4'h8) begin
						ptr_q   <= sr_q;
						oe_q    <= 1'b1;
						state_q <= ST_SACK;
					end
					ST_SACK, ST_WACK: begin
						oe_q    <= 1'b0;
						cnt_q   <= 4'h0;
						state_q <= ST_WR;
					end
					ST_WR: if (cnt_q == 4'h8) begin
						ptr_q   <= ptr_q + 8'h01;
						oe_q    <= 1'b1;
						state_q <= ST_WACK;
					end
					ST_RD: begin
						if (cnt_q == 4'h8) begin
							oe_q    <= 1'b0;
							state_q <= ST_RACK;
						end else begin
							oe_q  <= ~tx_q[7];
							tx_q  <= {tx_q[6:0], 1'b0};
							cnt_q <= cnt_q + 4'h1;
						end
					end
					ST_RACK: begin
						if (!rack_q) begin
							ptr_q   <= np;
							tx_q    <= {nextb[6:0], 1'b0};
							oe_q    <= ~nextb[7];
							cnt_q   <= 4'h1;
							state_q <= ST_RD;
						end else begin
							oe_q    <= 1'b0;
							state_q <= ST_IDLE;
						end
					end
					default: oe_q <= 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Register writes, strobes and results
	// ----------------------------------------
	// Strobe bits never land in storage, so they read back as zero
	wire trd_byte_t wdata = (ptr_q == `TRD_REG_CFG) ? (sr_q & ~`TRD_CFG_STROBES) : sr_q;
	wire        wr_ok     = wr_fire && ptr_q != `TRD_REG_TEMP && ptr_q <= `TRD_REG_LAST;
	wire        cfg_wr    = wr_fire && ptr_q == `TRD_REG_CFG;
	wire trd_byte_t temp_d = saturate(conv_celsius);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i <= 17; i++)
				regs_q[i] <= reset_val(5'(i));
		end else begin
			if (wr_ok)
				regs_q[ptr_q[4:0]] <= wdata;
			if (conv_done)
				regs_q[5'(`TRD_REG_TEMP)] <= temp_d;
		end
	end

	// Declared ahead of the scheduler, which reads the queue's answer
	trd_hot_if hq ();

	logic          clr_q;
	logic          trig_q;
	logic          samp_q;
	logic          over_q;
	logic          acq_q;
	logic          hot_q;
	logic          rearm_q;
	logic [TW-1:0] tmr_q;

	wire tmr_end = tmr_q == TW'(ACQ_PERIOD_CYC - 64'd1);
	wire signed [7:0] hot_thr = regs_q[5'(`TRD_REG_HOT)];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clr_q   <= 1'b0;
			trig_q  <= 1'b0;
			samp_q  <= 1'b0;
			over_q  <= 1'b0;
			acq_q   <= 1'b0;
			hot_q   <= 1'b0;
			rearm_q <= 1'b0;
			tmr_q   <= '0;
		end else begin
			clr_q   <= cfg_wr && sr_q[`TRD_CFG_CLR_BIT];
			trig_q  <= cfg_wr && sr_q[`TRD_CFG_TRIG_BIT];
			samp_q  <= conv_done;
			over_q  <= $signed(temp_d) > hot_thr;
			tmr_q   <= tmr_end ? '0 : tmr_q + TW'(1);
			acq_q   <= tmr_end || trig_q;
			hot_q   <= hq.hot;
			// Re-enabling rails never waits on fault flags being cleared
			rearm_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Fault queue
	// ----------------------------------------
	assign hq.sample = samp_q;
	assign hq.over   = over_q;
	assign hq.clear  = clr_q;
	assign hq.depth  = regs_q[5'(`TRD_REG_CFG)][`TRD_CFG_DEPTH_LSB +: 2];

	trd_hot_queue u_queue (
		.clk    (clk),
		.resetn (resetn),
		.hq     (hq.dst)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic sda_lo_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sda_lo_q <= 1'b0;
		else
			sda_lo_q <= 1'b0;
	end

	assign sda_o              = sda_lo_q;
	assign sda_oe             = oe_q;
	assign acq_start          = acq_q;
	assign temperature_result = regs_q[5'(`TRD_REG_TEMP)];
	assign pinned_read_enable = regs_q[5'(`TRD_REG_PIN)][`TRD_PIN_BIT];
	assign hot_alert          = hot_q;
	assign rail_rearm_ok      = rearm_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_start;
		start_det |=> state_q == ST_ADDR && cnt_q == 4'h0 && !oe_q;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_stop;
		stop_det && !start_det |=> state_q == ST_IDLE ##1 !oe_q;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");

	property p_addr_miss;
		state_q == ST_ADDR && byte_end && !addr_hit && !start_det && !stop_det
			|=> state_q == ST_IDLE && !oe_q;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

	property p_addr_ack;
		state_q == ST_ADDR && byte_end && addr_hit && !start_det && !stop_det
			|=> oe_q && state_q == ST_AACK;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

	property p_pin_hold;
		pin_on && state_q == ST_RACK && scl_fall && !rack_q && !start_det && !stop_det
			|=> ptr_q == $past(ptr_q);
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pinned pointer moved");

	property p_ptr_step;
		!pin_on && state_q == ST_RACK && scl_fall && !rack_q && !start_det && !stop_det
			|=> ptr_q == $past(ptr_q) + 8'h01;
	endproperty
	a_ptr_step: assert property (p_ptr_step) else $error("pointer not stepped");

	property p_pin_data;
		pin_on && state_q == ST_AACK && scl_fall && rw_q && !start_det && !stop_det
			|=> oe_q == ~$past(regs_q[0][7]) && tx_q == {$past(regs_q[0][6:0]), 1'b0};
	endproperty
	a_pin_data: assert property (p_pin_data) else $error("pinned read wrong data");

	property p_no_high;
		!sda_o;
	endproperty
	a_no_high: assert property (p_no_high) else $error("sda driven high");

	property p_strobe_zero;
		cfg_wr |=> regs_q[5'(`TRD_REG_CFG)][`TRD_CFG_CLR_BIT] == 1'b0 &&
			regs_q[5'(`TRD_REG_CFG)][`TRD_CFG_TRIG_BIT] == 1'b0 &&
			clr_q == $past(sr_q[`TRD_CFG_CLR_BIT]);
	endproperty
	a_strobe_zero: assert property (p_strobe_zero) else $error("clear strobe stuck");

	property p_period;
		tmr_end |=> acq_q && tmr_q == '0;
	endproperty
	a_period: assert property (p_period) else $error("acquisition not started");

	c_pin_read: cover property (pin_on && state_q == ST_RD ##[1:200] state_q == ST_RACK);
	c_write:    cover property (wr_fire && ptr_q == `TRD_REG_PIN);
	c_hot:      cover property (hot_q);
endmodule

/* File: core/trd_defines.svh */
// Constants of the temperature readout I2C target: addresses, fields, resets, timing
`ifndef TRD_DEFINES_SVH
`define TRD_DEFINES_SVH

// ----------------------------------------
// Bus address and register map
// ----------------------------------------
`define TRD_I2C_ADDR      7'h48
`define TRD_REG_TEMP      8'h00
`define TRD_REG_CFG       8'h0C
`define TRD_REG_HOT       8'h0D
`define TRD_REG_COOL      8'h0E
`define TRD_REG_PIN       8'h11
`define TRD_REG_LAST      8'h11

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TRD_CFG_TRIG_BIT  7
`define TRD_CFG_DEPTH_LSB 3
`define TRD_CFG_CLR_BIT   2
`define TRD_CFG_STROBES   8'h84
`define TRD_PIN_BIT       0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TRD_TEMP_RST      8'h00
`define TRD_CFG_RST       8'h20
`define TRD_HOT_RST       8'h32
`define TRD_COOL_RST      8'h2D
`define TRD_PIN_RST       8'h00

// ----------------------------------------
// Temperature limits and queue lengths
// ----------------------------------------
`define TRD_TEMP_MIN      10'sh3F6
`define TRD_TEMP_MAX      10'sh055
`define TRD_TEMP_MIN_B    8'hF6
`define TRD_TEMP_MAX_B    8'h55
`define TRD_QUE_N0        3'h1
`define TRD_QUE_N1        3'h2
`define TRD_QUE_N2        3'h4
`define TRD_QUE_N3        3'h6

// ----------------------------------------
// Timing
// ----------------------------------------
`define TRD_ACQ_PERIOD_S  60
`define TRD_CLK_HZ        100_000_000

`endif

/* File: core/trd_pkg.sv */
// Types of the temperature readout I2C target
package trd_pkg;

	typedef logic [7:0] trd_byte_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_AACK = 4'b0010,
		ST_SUB  = 4'b0011,
		ST_SACK = 4'b0100,
		ST_WR   = 4'b0101,
		ST_WACK = 4'b0110,
		ST_RD   = 4'b0111,
		ST_RACK = 4'b1000
	} trd_state_t;

endpackage

/* File: core/trd_hot_if.sv */
// Link between the target and its over-temperature queue
`timescale 1ns/1ns
interface trd_hot_if;
	logic       sample;
	logic       over;
	logic       clear;
	logic [1:0] depth;
	logic       hot;

	modport src (output sample, output over, output clear, output depth, input hot);
	modport dst (input sample, input over, input clear, input depth, output hot);
endinterface

/* File: core/trd_hot_queue.sv */
// Over-temperature fault queue: counts consecutive hot acquisitions
`timescale 1ns/1ns
`include "trd_defines.svh"
module trd_hot_queue (
	// System
	input wire logic clk,
	input wire logic resetn,
	// Link to the target
	trd_hot_if.dst   hq
);
	import trd_pkg::*;

	// ----------------------------------------
	// Queue counter
	// ----------------------------------------
	function automatic logic [2:0] need(input logic [1:0] d);
		case (d)
			2'b00:   need = `TRD_QUE_N0;
			2'b01:   need = `TRD_QUE_N1;
			2'b10:   need = `TRD_QUE_N2;
			default: need = `TRD_QUE_N3;
		endcase
	endfunction

	logic [2:0] cnt_q;
	logic       hot_q;

	// A sample in the clearing cycle still counts: the clear acts first
	wire  [2:0] base  = hq.clear ? 3'h0 : cnt_q;
	wire  [2:0] inc   = (base == `TRD_QUE_N3) ? base : base + 3'h1;
	wire  [2:0] cnt_d = !hq.sample ? base : (hq.over ? inc : 3'h0);
	wire        hot_d = hq.sample && hq.over && (inc >= need(hq.depth));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 3'h0;
			hot_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			hot_q <= hot_d;
		end
	end

	assign hq.hot = hot_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_queue_clear;
		hq.clear && !hq.sample |=> cnt_q == 3'h0;
	endproperty
	a_queue_clear: assert property (p_queue_clear) else $error("queue not cleared");

	property p_cool_reset;
		hq.sample && !hq.over |=> cnt_q == 3'h0 && !hot_q;
	endproperty
	a_cool_reset: assert property (p_cool_reset) else $error("queue kept count");

	property p_hot_depth;
		hot_q |-> cnt_q >= need($past(hq.depth)) && $past(hq.sample && hq.over);
	endproperty
	a_hot_depth: assert property (p_hot_depth) else $error("hot raised too early");

	c_hot: cover property (hot_q && $past(hq.depth) == 2'b11);
endmodule

/* File: tb/trd_bus_host.sv */
// Behavioural I2C bus controller that drives the target's pins
`timescale 1ns/1ns
module trd_bus_host (
	// Bus pins
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	// ----------------------------------------
	// Quarter period of the 80 ns bus clock
	// ----------------------------------------
	localparam int Q = 20;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// SCL rises 40 ns after a fall, past the target's 30 ns answer
	task automatic start();
		#Q;
		sda_pull = 1'b0;
		#Q;
		scl = 1'b1;
		#(2 * Q);
		sda_pull = 1'b1;
		#Q;
		scl = 1'b0;
	endtask

	task automatic stop();
		#Q;
		sda_pull = 1'b1;
		#Q;
		scl = 1'b1;
		#(2 * Q);
		sda_pull = 1'b0;
		#(2 * Q);
	endtask

	// SDA moves only while SCL is low; sampled just before the fall
	task automatic bit_io(input logic b, output logic r);
		#Q;
		sda_pull = ~b;
		#Q;
		scl = 1'b1;
		#(2 * Q - 1);
		r = sda;
		#1;
		scl = 1'b0;
	endtask

	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] r, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(ack_in, ack_out);
	endtask
endmodule

/* File: tb/trd_i2c_target_bench.sv */
// Self-checking bench of the temperature readout I2C target
`timescale 1ns/1ns
`include "trd_defines.svh"
module trd_i2c_target_bench;
	import trd_pkg::*;
	localparam int ACQ = 2000;
	logic              clk;
	logic              resetn;
	logic              scl;
	logic              host_pull;
	wire               sda;
	logic              sda_o;
	logic              sda_oe;
	logic              acq_start;
	logic              conv_done;
	logic signed [9:0] conv_celsius;
	trd_byte_t         temperature_result;
	logic              pinned_read_enable;
	logic              hot_alert;
	logic              rail_rearm_ok;
	int                fail_count = 0;
	int                n_compared = 0;
	int                n_hot = 0;
	int                n_acq = 0;
	int                need;
	int                n;
	int                k;
	integer            seed = 32'hea07;
	logic [7:0]        t_exp;
	logic [7:0]        r;
	logic              a;

	// Open drain wire with pull-up
	assign sda = ~host_pull & (sda_oe ? sda_o : 1'b1);

	trd_i2c_target #(.ACQ_PERIOD_CYC(ACQ)) i_dut (
		.clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .acq_start(acq_start), .conv_done(conv_done),
		.conv_celsius(conv_celsius), .temperature_result(temperature_result),
		.pinned_read_enable(pinned_read_enable), .hot_alert(hot_alert),
		.rail_rearm_ok(rail_rearm_ok)
	);
	trd_bus_host i_host (.scl(scl), .sda_pull(host_pull), .sda(sda));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (acq_start === 1'b1)
			n_acq++;
		if (hot_alert === 1'b1)
			n_hot++;
	end

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	function automatic logic [7:0] sat(input int c);
		if (c < -10)
			return 8'hF6;
		if (c > 85)
			return 8'h55;
		return c[7:0];
	endfunction

	function automatic int hot_val();
		return 31 + int'($unsigned($random(seed)) % 55);
	endfunction

	// ----------------------------------------
	// Bus and converter transactions
	// ----------------------------------------
	task automatic byte_out(input logic [7:0] d);
		logic [7:0] rr;
		logic       aa;
		i_host.xfer(d, 1'b1, rr, aa);
		chk(aa, 1'b0);
	endtask

	task automatic wr(input logic [7:0] sub, input logic [7:0] d0, d1, input bit two);
		i_host.start();
		byte_out({`TRD_I2C_ADDR, 1'b0});
		byte_out(sub);
		byte_out(d0);
		if (two)
			byte_out(d1);
		i_host.stop();
	endtask

	// Three bytes read, the last one refused by the host
	task automatic rd(input bit pin, input logic [7:0] sub, input logic [7:0] e0, e1, e2);
		logic [7:0] rr;
		logic       aa;
		i_host.start();
		if (!pin) begin
			byte_out({`TRD_I2C_ADDR, 1'b0});
			byte_out(sub);
			i_host.start();
		end
		byte_out({`TRD_I2C_ADDR, 1'b1});
		i_host.xfer(8'hFF, 1'b0, rr, aa);
		chk(rr, e0);
		i_host.xfer(8'hFF, 1'b0, rr, aa);
		chk(rr, e1);
		i_host.xfer(8'hFF, 1'b1, rr, aa);
		chk(rr, e2);
		i_host.stop();
	endtask

	task automatic conv(input int c);
		@(posedge clk);
		#1;
		conv_done = 1'b1;
		conv_celsius = 10'(c);
		@(posedge clk);
		#1;
		conv_done = 1'b0;
		t_exp = sat(c);
		repeat (6) @(posedge clk);
		#1;
		chk(temperature_result, t_exp);
	endtask

	task automatic wait_acq(output int cnt);
		cnt = 0;
		do begin
			@(posedge clk);
			#2;
			cnt++;
		end while (acq_start !== 1'b1 && cnt < 3 * ACQ);
		if (cnt >= 3 * ACQ) begin
			fail_count++;
			summarize();
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		conv_done = 1'b0;
		conv_celsius = '0;
		repeat (2) @(posedge clk);
		#1;
		resetn = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(temperature_result, 8'h00);
		chk(pinned_read_enable, 1'b0);
		chk(rail_rearm_ok, 1'b1);
		$display("test reset done");
		rd(0, 8'h0C, 8'h20, 8'h32, 8'h2D);
		wr(8'h0D, 8'h1E, 8'h0A, 1);
		rd(0, 8'h0D, 8'h1E, 8'h0A, 8'h00);
		rd(0, 8'h11, 8'h00, 8'h00, 8'h00);
		i_host.start();
		i_host.xfer({7'h49, 1'b0}, 1'b1, r, a);
		chk(a, 1'b1);
		i_host.stop();
		$display("test bus done");
		conv(-40);
		conv(120);
		conv(-10);
		conv(85);
		repeat (8) conv($random(seed) % 120);
		$display("test conversion done");
		// Cool value ends a hot run, the clear ends another
		for (int d = 0; d < 4; d++) begin
			need = (d == 0) ? 1 : (d == 1) ? 2 : (d == 2) ? 4 : 6;
			wr(8'h0C, {3'b000, 2'(d), 3'b100}, 8'h00, 0);
			rd(0, 8'h0C, {3'b000, 2'(d), 3'b000}, 8'h1E, 8'h0A);
			n_hot = 0;
			repeat (need - 1) conv(hot_val());
			conv(20);
			repeat (need - 1) conv(hot_val());
			wr(8'h0C, {3'b000, 2'(d), 3'b100}, 8'h00, 0);
			repeat (need - 1) conv(hot_val());
			chk(n_hot, 0);
			conv(hot_val());
			chk(n_hot, 1);
			$display("test depth %0d done", d);
		end
		wr(8'h11, 8'h01, 8'h00, 0);
		chk(pinned_read_enable, 1'b1);
		rd(1, 8'h00, t_exp, t_exp, t_exp);
		wr(8'h0D, 8'h28, 8'h0B, 1);
		wr(8'h11, 8'h00, 8'h00, 0);
		rd(0, 8'h0D, 8'h28, 8'h0B, 8'h00);
		$display("test pinned done");
		wait_acq(n);
		// Let the counter take the periodic pulse just seen before sampling it
		@(posedge clk);
		#1;
		k = n_acq;
		wr(8'h0C, 8'h80, 8'h00, 0);
		repeat (4) @(posedge clk);
		chk(n_acq - k, 1);
		wait_acq(n);
		wait_acq(n);
		chk(n, ACQ);
		$display("test acquisition done");
		summarize();
	end
endmodule
